// File: logic/serial_line_ctl.sv
// serial port line control, transmit pacing, loopback and pin sensing
// How it works
// - no connect lines selected means always connected during pass-through
// - connected while any selected CTS/DSR asserted; all low ends session
// - handshake none asserts every output line not used by rx flow
// - rx flow lines driven only by rx flow; handshake cannot touch them
// - on connect send a break of programmed ms; zero means no break
// - sample selected tx flow inputs before sending; withhold when not ready
// - outgoing data split into chunks of at most tx size, default 16
// - tx flow checked only at chunk start; chunk then finishes
// - idle gap of programmed bit times after every character, default 0
// - tx gap never affects receive speed or receive flow
// - loopback routes tx to rx internally; pins idle and ignored
// - loopback still honours tx flow control from the external lines
// - activity on both rx pins defers orientation until a character arrives
// - status shows both-analyzing while pending, then chosen pin Y
// - the character that decides pin 2 Y-lead orientation is discarded; one on pin 3 is kept
// - auto mode with two lines and no decision falls back to DTE
// - rx flow deasserts selected output lines, DTR by default
// - DTE receives pin 2, DCE swaps pins, auto senses negative idle
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
`include "line_ctl_cfg.svh"
module serial_line_ctl #(
    parameter int CYC_MS = `CYC_PER_MS,
    parameter int CHUNK_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial pins, pin2 and pin3 of the connector
    input wire logic pin2_rx_i,
    input wire logic pin3_rx_i,
    output logic pin2_tx_o,
    output logic pin3_tx_o,
    input wire line_ctl_pkg::modem_in_t modem_i,
    output line_ctl_pkg::modem_out_t modem_o,
    // session control from the pass-through side
    input wire logic pt_open_i,
    output logic pt_end_o
);
    import line_ctl_pkg::*;

    // software registers
    logic [31:0] ctrl_q, flow_q, txcfg_q, baud_q;
    logic [7:0] txd_q;
    logic txd_full_q;
    logic [7:0] rxd_q;
    logic rxd_full_q;
    logic rx_stop_q;
    // ctrl: [1:0] pin mode, [2] loopback, [3] rx flow stop, [31:16] break ms
    // flow: [1:0] rx flow lines, [3:2] handshake lines, [5:4] check lines,
    //       [9:8] tx flow lines cts/dsr
    // txcfg: [7:0] tx size, [15:8] tx pause bits
    pin_mode_t pin_mode;
    logic loop_en;
    logic [15:0] break_ms;
    logic [1:0] rxf_sel, hs_sel, chk_sel, txf_sel;
    logic [7:0] tx_size, tx_pause;
    assign pin_mode = pin_mode_t'(ctrl_q[1:0]);
    assign loop_en = ctrl_q[2];
    assign break_ms = ctrl_q[31:16];
    assign rxf_sel = flow_q[1:0];
    assign hs_sel = flow_q[3:2];
    assign chk_sel = flow_q[5:4];
    assign txf_sel = flow_q[9:8];
    assign tx_size = txcfg_q[7:0];
    assign tx_pause = txcfg_q[15:8];

    // pin synchronisers; first stage read only by the second
    logic [5:0] sync1_q, sync2_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 6'h3F;
            sync2_q <= 6'h3F;
        end else begin
            sync1_q <= {pin2_rx_i, pin3_rx_i, modem_i.cts, modem_i.dsr,
                        modem_i.dcd, modem_i.ri};
            sync2_q <= sync1_q;
        end
    end
    logic p2_s, p3_s, cts_s, dsr_s;
    assign p2_s = sync2_q[5];
    assign p3_s = sync2_q[4];
    assign cts_s = sync2_q[3];
    assign dsr_s = sync2_q[2];

    // connection state
    logic conn;
    logic conn_q;
    always_comb begin
        if (chk_sel == 2'b00) begin
            conn = pt_open_i;
        end else begin
            conn = pt_open_i &&
                ((chk_sel[1] && cts_s) || (chk_sel[0] && dsr_s));
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conn_q <= 1'b0;
            pt_end_o <= 1'b0;
        end else begin
            conn_q <= conn;
            pt_end_o <= conn_q && !conn && pt_open_i;
        end
    end

    // output control lines, bit1 rts bit0 dtr
    logic [1:0] hs_lines, out_lines;
    always_comb begin
        hs_lines = (hs_sel == 2'b00) ? 2'b11 : hs_sel;
        out_lines = (conn_q ? hs_lines : 2'b00) & ~rxf_sel;
        out_lines = out_lines | (rxf_sel & {2{!rx_stop_q}});
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modem_o <= '0;
        end else begin
            modem_o <= '{rts: out_lines[1], dtr: out_lines[0]};
        end
    end

    // orientation sensing
    rx_pin_t rxp_q;
    logic y_first_q;
    logic p2_act_q, p3_act_q;
    logic rx_line;
    logic use_pin3;
    always_comb begin
        unique case (pin_mode)
            PIN_DCE: use_pin3 = 1'b1;
            PIN_AUTO: use_pin3 = (rxp_q == RXP_PIN3Y) ||
                (rxp_q == RXP_NONE && p3_act_q && !p2_act_q);
            default: use_pin3 = 1'b0;
        endcase
    end

    // transmit engine
    tx_state_t st_q;
    logic [31:0] brk_cnt_q;
    logic [15:0] ms_q;
    logic [CHUNK_W-1:0] chunk_q;
    logic [23:0] gap_q;
    logic fr_go, fr_busy, fr_tx, fr_stb, conn_d1_q;
    logic [7:0] fr_rx;
    logic tx_ok;
    assign tx_ok = !((txf_sel[1] && !cts_s) || (txf_sel[0] && !dsr_s));
    assign fr_go = (st_q == TX_SEND) && txd_full_q && !fr_busy;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= TX_IDLE;
            brk_cnt_q <= '0;
            ms_q <= '0;
            chunk_q <= '0;
            gap_q <= '0;
            conn_d1_q <= 1'b0;
        end else begin
            conn_d1_q <= conn_q;
            unique case (st_q)
                TX_IDLE: begin
                    if (conn_q && !conn_d1_q && break_ms != '0) begin
                        st_q <= TX_BREAK;
                        ms_q <= break_ms;
                        brk_cnt_q <= '0;
                    end else if (txd_full_q && tx_ok) begin
                        st_q <= TX_SEND;
                        chunk_q <= CHUNK_W'((tx_size == 8'h00) ?
                            8'h01 : tx_size);
                    end
                end
                TX_BREAK: begin
                    if (brk_cnt_q == 32'(CYC_MS - 1)) begin
                        brk_cnt_q <= '0;
                        ms_q <= ms_q - 16'h1;
                        if (ms_q == 16'h1) begin
                            st_q <= TX_IDLE;
                        end
                    end else begin
                        brk_cnt_q <= brk_cnt_q + 32'h1;
                    end
                end
                TX_SEND: begin
                    if (fr_go) begin
                        chunk_q <= chunk_q - 1'b1;
                        gap_q <= 24'(tx_pause) *
                            (24'(baud_q[15:0]) + 24'h1);
                        st_q <= TX_GAP;
                    end
                end
                TX_GAP: begin
                    if (!fr_busy) begin
                        if (gap_q != '0) begin
                            gap_q <= gap_q - 24'h1;
                        end else if (chunk_q == '0) begin
                            st_q <= TX_IDLE;
                        end else if (txd_full_q) begin
                            st_q <= TX_SEND;
                        end else begin
                            st_q <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // line idles marking; break forces spacing
    logic tx_line;
    assign tx_line = (st_q == TX_BREAK) ? 1'b0 : fr_tx;
    assign rx_line = loop_en ? fr_tx : (use_pin3 ? p3_s : p2_s);

    // framing fixed, pacing only spaces characters; gap is tx only
    char_frame #(.DIV_W(16)) u_frame (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bit_div(baud_q[15:0]),
        .tx_go(fr_go),
        .tx_byte(txd_q),
        .tx_busy(fr_busy),
        .tx_line(fr_tx),
        .rx_line(rx_line),
        .rx_stb(fr_stb),
        .rx_byte(fr_rx)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin2_tx_o <= 1'b1;
            pin3_tx_o <= 1'b1;
        end else begin
            pin2_tx_o <= loop_en ? 1'b1 : (use_pin3 ? tx_line : 1'b1);
            pin3_tx_o <= loop_en ? 1'b1 : (use_pin3 ? 1'b1 : tx_line);
        end
    end

    // activity seen as line going to spacing at least once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            p2_act_q <= 1'b0;
            p3_act_q <= 1'b0;
            rxp_q <= RXP_NONE;
            y_first_q <= 1'b0;
        end else begin
            y_first_q <= 1'b0;
            if (!p2_s) p2_act_q <= 1'b1;
            if (!p3_s) p3_act_q <= 1'b1;
            if (pin_mode != PIN_AUTO) begin
                rxp_q <= RXP_NONE;
                p2_act_q <= 1'b0;
                p3_act_q <= 1'b0;
            end else if (rxp_q == RXP_NONE && p2_act_q && p3_act_q) begin
                rxp_q <= RXP_BOTH;
            end else if (rxp_q == RXP_BOTH && !loop_en && fr_stb) begin
                // character arrived on default pin 2 so pin 2 talks
                rxp_q <= RXP_PIN2Y;
                y_first_q <= 1'b1;
            end else if (rxp_q == RXP_BOTH && !p3_s && p2_s) begin
                rxp_q <= RXP_PIN3Y;
                y_first_q <= 1'b1;
            end
        end
    end

    // wishbone slave, ack one cycle after strobe
    logic req;
    logic [3:0] widx;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign widx = wb_adr_i[5:2];

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RST;
            flow_q <= `FLOW_RST;
            txcfg_q <= `TXCFG_RST;
            baud_q <= `BAUD_RST;
            txd_q <= 8'h00;
            txd_full_q <= 1'b0;
            rx_stop_q <= 1'b0;
        end else begin
            if (fr_go) txd_full_q <= 1'b0;
            if (req && wb_we_i) begin
                unique case (widx)
                    `ADR_CTRL: begin
                        ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
                        if (wb_sel_i[0]) rx_stop_q <= wb_dat_i[3];
                    end
                    `ADR_FLOW: flow_q <= merge(flow_q, wb_dat_i, wb_sel_i);
                    `ADR_TXCFG: txcfg_q <= merge(txcfg_q, wb_dat_i, wb_sel_i);
                    `ADR_BAUD: baud_q <= merge(baud_q, wb_dat_i, wb_sel_i);
                    `ADR_TXDATA: begin
                        if (wb_sel_i[0] && !txd_full_q) begin
                            txd_q <= wb_dat_i[7:0];
                            txd_full_q <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // receive holding register; set wins over the read clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxd_q <= 8'h00;
            rxd_full_q <= 1'b0;
        end else if (fr_stb && !y_first_q && rxp_q != RXP_BOTH) begin
            rxd_q <= fr_rx;
            rxd_full_q <= 1'b1;
        end else if (req && !wb_we_i && widx == `ADR_RXDATA) begin
            rxd_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                unique case (widx)
                    `ADR_CTRL: wb_dat_o <= ctrl_q;
                    `ADR_FLOW: wb_dat_o <= flow_q;
                    `ADR_TXCFG: wb_dat_o <= txcfg_q;
                    `ADR_BAUD: wb_dat_o <= baud_q;
                    `ADR_TXDATA: wb_dat_o <= {23'h0, txd_full_q, txd_q};
                    `ADR_STATUS: wb_dat_o <= {22'h0, st_q, rxp_q, conn_q,
                        tx_ok, modem_o.rts, modem_o.dtr, cts_s, dsr_s};
                    `ADR_RXDATA: wb_dat_o <= {23'h0, rxd_full_q, rxd_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : serial_line_ctl

// File: inc/line_ctl_cfg.svh
// register offsets, reset values, field defaults and timing counts
`ifndef LINE_CTL_CFG_SVH
`define LINE_CTL_CFG_SVH
`define ADR_CTRL 4'h0
`define ADR_FLOW 4'h1
`define ADR_TXCFG 4'h2
`define ADR_TXDATA 4'h3
`define ADR_STATUS 4'h4
`define ADR_RXDATA 4'h5
`define ADR_BAUD 4'h6
`define CTRL_RST 32'h0000_0000
`define FLOW_RST 32'h0000_0101
`define TXCFG_RST 32'h0000_0010
`define BAUD_RST 32'h0000_0364
`define TX_SIZE_DEF 8'h10
`define TX_PAUSE_DEF 8'h00
`define BREAK_MS_DEF 16'h0000
`define CLK_HZ 100000000
`define MS_PER_S 1000
`define CYC_PER_MS (`CLK_HZ / `MS_PER_S)
`endif

// File: inc/line_ctl_pkg.sv
// types shared by the serial line control logic
package line_ctl_pkg;
    typedef struct packed {
        logic cts;
        logic dsr;
        logic dcd;
        logic ri;
    } modem_in_t;
    typedef struct packed {
        logic rts;
        logic dtr;
    } modem_out_t;
    typedef enum logic [1:0] {
        PIN_DTE = 2'h0,
        PIN_DCE = 2'h1,
        PIN_AUTO = 2'h3,
        PIN_DIAG = 2'h2
    } pin_mode_t;
    typedef enum logic [1:0] {
        RXP_NONE = 2'h0,
        RXP_BOTH = 2'h1,
        RXP_PIN2Y = 2'h3,
        RXP_PIN3Y = 2'h2
    } rx_pin_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_BREAK = 2'h2,
        TX_SEND = 2'h1,
        TX_GAP = 2'h3
    } tx_state_t;
endpackage : line_ctl_pkg

// File: logic/char_frame.sv
// one serial character framer, used for transmit and receive
`timescale 1ns/1ns
module char_frame #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bit period in clocks, less one
    input wire logic [DIV_W-1:0] bit_div,
    // transmit side
    input wire logic tx_go,
    input wire logic [7:0] tx_byte,
    output logic tx_busy,
    output logic tx_line,
    // receive side
    input wire logic rx_line,
    output logic rx_stb,
    output logic [7:0] rx_byte
);
    logic [DIV_W-1:0] tcnt_q;
    logic [3:0] tbit_q;
    logic [9:0] tsh_q;
    logic [DIV_W-1:0] rcnt_q;
    logic [3:0] rbit_q;
    logic [7:0] rsh_q;
    logic ract_q;

    assign tx_busy = (tbit_q != 4'h0);

    // framing is fixed: start, eight data, one stop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tcnt_q <= '0;
            tbit_q <= 4'h0;
            tsh_q <= 10'h3FF;
        end else if (tbit_q == 4'h0) begin
            if (tx_go) begin
                tsh_q <= {1'b1, tx_byte, 1'b0};
                tbit_q <= 4'hA;
                tcnt_q <= bit_div;
            end
        end else if (tcnt_q == '0) begin
            tsh_q <= {1'b1, tsh_q[9:1]};
            tbit_q <= tbit_q - 4'h1;
            tcnt_q <= bit_div;
        end else begin
            tcnt_q <= tcnt_q - 1'b1;
        end
    end
    assign tx_line = tsh_q[0];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_q <= '0;
            rbit_q <= 4'h0;
            rsh_q <= 8'h00;
            ract_q <= 1'b0;
            rx_stb <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_stb <= 1'b0;
            if (!ract_q) begin
                if (!rx_line) begin
                    ract_q <= 1'b1;
                    rbit_q <= 4'h0;
                    rcnt_q <= bit_div >> 1;
                end
            end else if (rcnt_q != '0) begin
                rcnt_q <= rcnt_q - 1'b1;
            end else begin
                rcnt_q <= bit_div;
                rbit_q <= rbit_q + 4'h1;
                if (rbit_q == 4'h0 && rx_line) begin
                    ract_q <= 1'b0;
                end else if (rbit_q >= 4'h1 && rbit_q <= 4'h8) begin
                    rsh_q <= {rx_line, rsh_q[7:1]};
                end else if (rbit_q == 4'h9) begin
                    ract_q <= 1'b0;
                    rx_stb <= rx_line;
                    rx_byte <= rsh_q;
                end
            end
        end
    end
endmodule : char_frame

// File: verif/line_ctl_sva.sv
// checker for the serial line control top module ports
`timescale 1ns/1ns
module line_ctl_sva #(
    parameter int CYC_MS = 10,
    parameter int CHUNK_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // serial and modem lines
    input wire logic pin2_rx_i,
    input wire logic pin3_rx_i,
    input wire logic pin2_tx_o,
    input wire logic pin3_tx_o,
    input wire line_ctl_pkg::modem_in_t modem_i,
    input wire line_ctl_pkg::modem_out_t modem_o,
    // session
    input wire logic pt_open_i,
    input wire logic pt_end_o
);
    import line_ctl_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence answer_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_follows_req_a: assert property (req_s |=> answer_s)
        else $error("no single ack one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property ( // unmapped reads give zero
        wb_ack_o && !wb_we_i && wb_adr_i[5:2] > 4'h6 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    end_single_a: assert property (pt_end_o |=> !pt_end_o)
        else $error("session end longer than one cycle");
    end_open_a: assert property (pt_end_o |-> $past(pt_open_i))
        else $error("session end without open session");
    pins_one_used_a: assert property (pin2_tx_o || pin3_tx_o)
        else $error("both transmit pins low");
    reset_quiet_a: assert property ($rose(rst_n) |->
        !wb_ack_o && pin2_tx_o && pin3_tx_o && modem_o == 2'h0 && !pt_end_o)
        else $error("outputs not idle after reset");
    idle_no_ack_a: assert property (!wb_stb_i ##1 !wb_stb_i |-> !wb_ack_o)
        else $error("ack while bus idle");
endmodule : line_ctl_sva

// File: verif/rs232_peer.sv
// far-side rs-232 device: byte receiver, byte sender, modem lines
`timescale 1ns/1ns
module rs232_peer (
    // clock
    input wire logic clk_sys,
    // link
    input wire logic [15:0] bit_clks,
    input wire logic rx_line,
    output logic tx_line,
    output line_ctl_pkg::modem_in_t modem
);
    import line_ctl_pkg::*;
    logic [7:0] rx_q[$];
    longint rx_t[$];
    logic [7:0] b;
    longint t0;
    initial begin
        tx_line = 1'b1;
        modem = '0;
    end
    // samples mid-bit; a break reads as a zero byte
    initial forever begin
        @(posedge clk_sys);
        if (rx_line === 1'b0) begin
            t0 = $time;
            repeat (bit_clks / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_clks) @(posedge clk_sys);
                b[i] = rx_line;
            end
            repeat (bit_clks) @(posedge clk_sys);
            rx_q.push_back(b);
            rx_t.push_back(t0);
            while (rx_line !== 1'b1) @(posedge clk_sys);
        end
    end
    task automatic send_byte(input logic [7:0] v);
        @(posedge clk_sys);
        tx_line <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            repeat (bit_clks) @(posedge clk_sys);
            tx_line <= (i == 8) ? 1'b1 : v[i];
        end
        repeat (bit_clks) @(posedge clk_sys);
    endtask : send_byte
    task automatic set_lines(input logic c, input logic d);
        @(posedge clk_sys);
        modem <= '{cts: c, dsr: d, dcd: 1'b0, ri: 1'b0};
    endtask : set_lines
endmodule : rs232_peer

// File: verif/serial_port_line_control_tb.sv
// testbench for the serial line control block
`timescale 1ns/1ns
`include "line_ctl_cfg.svh"
module serial_port_line_control_tb;
    import line_ctl_pkg::*;
    localparam int CYC_MS = 10;
    logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic pin2_tx_o, pin3_tx_o, pin3_rx_i, peer_tx, pt_open_i, pt_end_o;
    modem_in_t modem_i;
    modem_out_t modem_o;
    int failures, tests_run, lows, l0, n;
    logic seen;
    serial_line_ctl #(.CYC_MS(CYC_MS), .CHUNK_W(8)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin2_rx_i(peer_tx), .pin3_rx_i(pin3_rx_i),
        .pin2_tx_o(pin2_tx_o), .pin3_tx_o(pin3_tx_o), .modem_i(modem_i),
        .modem_o(modem_o), .pt_open_i(pt_open_i), .pt_end_o(pt_end_o));
    rs232_peer u_peer (.clk_sys(clk_sys), .bit_clks(16'h0004),
        .rx_line(pin3_tx_o), .tx_line(peer_tx), .modem(modem_i));
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (!pin2_tx_o || !pin3_tx_o) lows++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wbx(input logic we, input logic [3:0] idx,
                       input logic [31:0] wd);
        int k;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 100);
        if (k >= 100) failures++;
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wbx
    task automatic open_pt(input logic v);
        @(posedge clk_sys);
        pt_open_i <= v;
    endtask : open_pt
    task automatic wait_free();
        for (int i = 0; i < 50; i++) begin
            wbx(0, `ADR_TXDATA, 0);
            if (rd[8] === 1'b0) break;
        end
    endtask : wait_free
    task automatic wait_rx(input int cnt);
        for (int i = 0; i < 2000 && u_peer.rx_q.size() < cnt; i++)
            @(posedge clk_sys);
    endtask : wait_rx
    task automatic t_regs();
        wbx(0, `ADR_CTRL, 0); chk(rd, `CTRL_RST);
        wbx(0, `ADR_FLOW, 0); chk(rd, `FLOW_RST);
        wbx(0, `ADR_TXCFG, 0); chk(rd, `TXCFG_RST);
        wbx(0, `ADR_BAUD, 0); chk(rd, `BAUD_RST);
        wbx(1, 4'h7, 32'hFFFF_FFFF);
        wbx(0, 4'h7, 0); chk(rd, 32'h0);
        wbx(1, `ADR_BAUD, 32'h0000_0003);
    endtask : t_regs
    task automatic t_session();
        wbx(1, `ADR_FLOW, 32'h0000_0001);
        l0 = lows;
        open_pt(1);
        repeat (30) @(posedge clk_sys);
        chk(lows - l0, 0);
        chk(modem_o, 2'h3);
        wbx(1, `ADR_CTRL, 32'h0000_0008);
        repeat (6) @(posedge clk_sys);
        chk(modem_o, 2'h2);
        wbx(1, `ADR_FLOW, 32'h0000_0003);
        repeat (6) @(posedge clk_sys);
        chk(modem_o, 2'h0);
        wbx(1, `ADR_CTRL, 0);
        open_pt(0);
    endtask : t_session
    task automatic t_check();
        wbx(1, `ADR_FLOW, 32'h0000_0020);
        u_peer.set_lines(1, 0);
        open_pt(1);
        repeat (8) @(posedge clk_sys);
        chk(modem_o.rts, 1);
        u_peer.set_lines(0, 0);
        seen = 0;
        repeat (20) begin
            @(posedge clk_sys);
            if (pt_end_o === 1'b1) seen = 1;
        end
        chk(seen, 1);
        chk(modem_o.rts, 0);
        open_pt(0);
    endtask : t_check
    task automatic t_break();
        wbx(1, `ADR_FLOW, 0);
        wbx(1, `ADR_CTRL, 32'h0002_0000);
        open_pt(1);
        n = 0;
        for (int i = 0; i < 20 && pin3_tx_o !== 1'b0; i++) @(posedge clk_sys);
        while (pin3_tx_o === 1'b0 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n, 2 * CYC_MS);
        repeat (60) @(posedge clk_sys);
        u_peer.rx_q.delete();
        u_peer.rx_t.delete();
        open_pt(0);
        wbx(1, `ADR_CTRL, 0);
    endtask : t_break
    task automatic t_gap();
        for (int p = 0; p < 2; p++) begin
            wbx(1, `ADR_TXCFG, (p * 10) << 8 | 32'h10);
            wbx(1, `ADR_TXDATA, 32'h0000_00A5);
            wait_free();
            wbx(1, `ADR_TXDATA, 32'h0000_003C);
            wait_rx(2);
            chk(u_peer.rx_q[0], 8'hA5);
            chk(u_peer.rx_q[1], 8'h3C);
            chk(u_peer.rx_t[1] - u_peer.rx_t[0],
                (10 + p * 10) * 40 + 20);
            u_peer.rx_q.delete();
            u_peer.rx_t.delete();
        end
    endtask : t_gap
    task automatic t_flow();
        wbx(1, `ADR_FLOW, 32'h0000_0200);
        wbx(1, `ADR_TXCFG, 32'h0000_0002);
        wbx(1, `ADR_TXDATA, 32'h0000_0011);
        repeat (60) @(posedge clk_sys);
        chk(u_peer.rx_q.size(), 0);
        u_peer.set_lines(1, 0);
        wait_free();
        wbx(1, `ADR_TXDATA, 32'h0000_0022);
        u_peer.set_lines(0, 0);
        repeat (120) @(posedge clk_sys);
        chk(u_peer.rx_q.size(), 2);
        wbx(1, `ADR_TXDATA, 32'h0000_0033);
        repeat (120) @(posedge clk_sys);
        chk(u_peer.rx_q.size(), 2);
        u_peer.set_lines(1, 0);
        wait_rx(3);
        chk(u_peer.rx_q[2], 8'h33);
        u_peer.rx_q.delete();
        u_peer.set_lines(0, 0);
    endtask : t_flow
    task automatic t_rx_loop();
        u_peer.send_byte(8'h5A);
        repeat (10) @(posedge clk_sys);
        wbx(0, `ADR_RXDATA, 0); chk(rd[8:0], 9'h15A);
        wbx(1, `ADR_CTRL, 32'h0000_0004);
        l0 = lows;
        wbx(1, `ADR_TXDATA, 32'h0000_0096);
        u_peer.send_byte(8'h00);
        repeat (40) @(posedge clk_sys);
        chk(lows - l0, 0);
        chk(u_peer.rx_q.size(), 0);
        wbx(0, `ADR_RXDATA, 0); chk(rd[8], 0);
        u_peer.set_lines(1, 0);
        repeat (60) @(posedge clk_sys);
        wbx(0, `ADR_RXDATA, 0); chk(rd[8:0], 9'h196);
        wbx(1, `ADR_CTRL, 32'h0000_0003);
        pin3_rx_i <= 1'b0;
        @(posedge clk_sys) pin3_rx_i <= 1'b1;
        u_peer.send_byte(8'hC3);
        repeat (10) @(posedge clk_sys);
        wbx(0, `ADR_RXDATA, 0); chk(rd[8], 0);
        wbx(0, `ADR_STATUS, 0); chk(rd[7:6], 2'h3);
        u_peer.send_byte(8'h3C);
        repeat (10) @(posedge clk_sys);
        wbx(0, `ADR_RXDATA, 0); chk(rd[8:0], 9'h13C);
    endtask : t_rx_loop
    task automatic wrap_up();
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin
        {clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, pt_open_i} = '0;
        {wb_adr_i, wb_dat_i, failures, tests_run, lows} = '0;
        wb_sel_i = 4'hF;
        pin3_rx_i = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_session();
        t_check();
        t_break();
        t_gap();
        t_flow();
        t_rx_loop();
        wrap_up();
    end
    // the run needs some eleven hundred cycles
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
endmodule : serial_port_line_control_tb
bind serial_line_ctl line_ctl_sva #(.CYC_MS(CYC_MS), .CHUNK_W(CHUNK_W)) u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin2_rx_i(pin2_rx_i), .pin3_rx_i(pin3_rx_i),
    .pin2_tx_o(pin2_tx_o), .pin3_tx_o(pin3_tx_o), .modem_i(modem_i),
    .modem_o(modem_o), .pt_open_i(pt_open_i), .pt_end_o(pt_end_o));
